/* File: rtl/watchdog_control_status_regs.sv */
// watchdog lock, restart flag, reset counter, output config, soft reset
// assumes the window timer on the same clock reports reset pulses and
// the nonvolatile image is presented steadily on the nvConfig ports
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps

// Function
// - lock bit is sticky; only a reset returns it to zero
// - while locked, writes to both config registers are dropped
// - status register stays writable while locked
// - reload nonvolatile config on restart only when reload bit set
// - pull-down on trigger input follows the pull-down select bit
// - reset output active high at polarity zero, active low at one
// - drive type zero push-pull, one open-drain; reset loads it from the image
// - config defaults come from the nonvolatile image, except the lock bit, which resets to zero
// - flag clear bit makes one clear pulse, then reads zero
// - restart sets the flag; it holds until software clears it
// - counter clear bit makes a pulse that zeroes the counter
// - counter value reads in status bits one to zero
// - software reset restores defaults, reloads memory, self-clears
// - count reset pulses, restart at 1, 2 or 4; code 00 disables
module watchdog_control_status_regs #(
   parameter int ADDR_W = 8
) (
   input  wire logic                             clk,
   input  wire logic                             rst,
   input  wire logic [ADDR_W-1:0]                addr,
   input  wire logic [7:0]                       wrData,
   input  wire logic                             wrEn,
   input  wire logic                             rdEn,
   output      logic [7:0]                       rdData,
   input  wire wdt_regs_pkg::watchdogConfigOne_t nvConfigOne,
   input  wire wdt_regs_pkg::watchdogConfigTwo_t nvConfigTwo,
   input  wire logic                             resetPulse,
   input  wire logic                             resetActive,
   output      wdt_regs_pkg::watchdogConfigOne_t configOne,
   output      wdt_regs_pkg::watchdogConfigTwo_t configTwo,
   output      logic                             nvReadReq,
   output      logic                             systemRestartReq,
   output      logic                             watchdogResetOutput,
   output      logic                             watchdogResetOutputOe,
   output      logic                             triggerPulldownEn,
   output      logic                             irq
);

   // ************************************************************
   // parameter check
   // ************************************************************
   if (ADDR_W < 6) begin : gBadAddr
      $error("ADDR_W too narrow for the register map");
   end

   // ************************************************************
   // decode
   // ************************************************************
   function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
      regHit = (a == ADDR_W'(ofs));
   endfunction : regHit

   function automatic logic [1:0] fireCount(input logic [1:0] thr);
      fireCount = (thr == wdt_regs_pkg::THR_ONE) ? wdt_regs_pkg::AT_ONE :
                  (thr == wdt_regs_pkg::THR_TWO) ? wdt_regs_pkg::AT_TWO :
                  wdt_regs_pkg::AT_FOUR;
   endfunction : fireCount

   logic [1:0] count;
   logic       restartFlag;
   logic       clrFlag;
   logic       clrCnt;
   logic [2:0] stsSpare;
   logic       swResetArm;
   logic [6:0] swSpare;
   logic [1:0] intStatus;
   logic [1:0] intMask;
   wdt_regs_pkg::watchdogConfigTwo_t wrCfgTwo;

   wire hitCfg1   = regHit(addr, wdt_regs_pkg::OFS_CFG1);
   wire hitCfg2   = regHit(addr, wdt_regs_pkg::OFS_CFG2);
   wire hitStatus = regHit(addr, wdt_regs_pkg::OFS_STATUS);
   wire hitSwrst  = regHit(addr, wdt_regs_pkg::OFS_SWRST);
   wire hitIntSt  = regHit(addr, wdt_regs_pkg::OFS_INTST);
   wire hitIntMk  = regHit(addr, wdt_regs_pkg::OFS_INTMASK);
   assign wrCfgTwo = wrData;

   wire locked    = configTwo.configLockBit;
   wire wrCfg1    = wrEn & hitCfg1 & ~locked;
   wire wrCfg2    = wrEn & hitCfg2 & ~locked;
   wire wrStatus  = wrEn & hitStatus;
   wire wrSwrst   = wrEn & hitSwrst;
   wire wrIntSt   = wrEn & hitIntSt;
   wire wrIntMk   = wrEn & hitIntMk;

   // ************************************************************
   // reset counter and restart decision
   // ************************************************************
   // a threshold lowered under the running count still fires
   wire [1:0] thr       = configOne.resetCounterThreshold;
   wire       thrHit    = resetPulse & (thr != wdt_regs_pkg::THR_OFF)
                          & (count >= fireCount(thr));
   wire       inhibit   = configTwo.restartFlagModeBit & restartFlag;
   wire       restartNow = thrHit & ~inhibit;
   wire       reloadNow  = restartNow
                           & configTwo.nonvolatileReloadOnRestart;

   // a clear and a pulse in one cycle leave the pulse counted
   wire [1:0] cntBase    = clrCnt ? wdt_regs_pkg::RST_CNT : count;
   wire [1:0] cntInc     = (cntBase == wdt_regs_pkg::CNT_MAX) ? cntBase :
                           cntBase + wdt_regs_pkg::CNT_STEP;
   wire [1:0] next_count = restartNow ? wdt_regs_pkg::RST_CNT :
                           resetPulse ? cntInc : cntBase;

   // set wins over clear
   wire next_restartFlag = restartNow | (restartFlag & ~clrFlag);

   wire [1:0] intEvents;
   assign intEvents[wdt_regs_pkg::INT_RESTART] = restartNow;
   assign intEvents[wdt_regs_pkg::INT_PULSE]   = resetPulse;
   wire [1:0] intW1c = wrIntSt ? wrData[1:0] : 2'h0;
   wire [1:0] next_intStatus = (intStatus & ~intW1c) | intEvents;

   // ************************************************************
   // read mux
   // ************************************************************
   wire [7:0] statusByte = {stsSpare, clrFlag, restartFlag, clrCnt,
                            count};
   wire [7:0] rdMux = hitCfg1   ? configOne :
                      hitCfg2   ? configTwo :
                      hitStatus ? statusByte :
                      hitSwrst  ? {swSpare, swResetArm} :
                      hitIntSt  ? {6'h00, intStatus} :
                      hitIntMk  ? {6'h00, intMask} :
                      wdt_regs_pkg::RST_BYTE;

   // ************************************************************
   // config registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst || swResetArm) begin
         configOne <= nvConfigOne;
         configTwo <= nvConfigTwo;
         configTwo.configLockBit <= 1'b0;
      end else if (reloadNow) begin
         configOne <= nvConfigOne;
         configTwo <= nvConfigTwo;
         configTwo.configLockBit <= locked;
      end else begin
         if (wrCfg1) begin
            configOne <= wrData;
         end
         if (wrCfg2) begin
            // once set, only a reset brings the lock back down
            configTwo <= wrData;
            configTwo.configLockBit <= locked | wrCfgTwo.configLockBit;
         end
      end
   end

   // ************************************************************
   // status, soft reset and interrupt registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst || swResetArm) begin
         count       <= wdt_regs_pkg::RST_CNT;
         restartFlag <= 1'b0;
         clrFlag     <= 1'b0;
         clrCnt      <= 1'b0;
         stsSpare    <= 3'h0;
         swSpare     <= 7'h00;
         intStatus   <= 2'h0;
         intMask     <= 2'h0;
      end else begin
         count       <= next_count;
         restartFlag <= next_restartFlag;
         clrFlag     <= wrStatus & wrData[wdt_regs_pkg::STS_CLRFLAG];
         clrCnt      <= wrStatus & wrData[wdt_regs_pkg::STS_CLRCNT];
         intStatus   <= next_intStatus;
         if (wrStatus) begin
            stsSpare <= wrData[7:5];
         end
         if (wrSwrst) begin
            swSpare <= wrData[7:1];
         end
         if (wrIntMk) begin
            intMask <= wrData[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         swResetArm <= 1'b0;
      end else begin
         swResetArm <= ~swResetArm & wrSwrst
                       & wrData[wdt_regs_pkg::SWRST_BIT];
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         rdData                <= wdt_regs_pkg::RST_BYTE;
         nvReadReq             <= 1'b0;
         systemRestartReq      <= 1'b0;
         watchdogResetOutput   <= 1'b0;
         watchdogResetOutputOe <= 1'b0;
      end else begin
         rdData           <= rdEn ? rdMux : wdt_regs_pkg::RST_BYTE;
         nvReadReq        <= swResetArm | reloadNow;
         systemRestartReq <= restartNow;
         watchdogResetOutput <= resetActive
                                ^ configTwo.resetOutputPolarity;
         // open-drain only pulls low
         watchdogResetOutputOe <= ~configTwo.resetOutputDriveType
                                  | ~(resetActive
                                  ^ configTwo.resetOutputPolarity);
      end
   end

   assign triggerPulldownEn = configTwo.triggerInputPulldownSel;
   assign irq = |(intStatus & ~intMask);

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_LOCK_STICKY: assert property (
      locked && !swResetArm |=> configTwo.configLockBit)
      else $error("lock bit dropped without reset");

   AST_LOCK_BLOCKS: assert property (
      locked && wrEn && (hitCfg1 || hitCfg2) && !swResetArm && !reloadNow
      |=> $stable(configOne) && $stable(configTwo))
      else $error("locked config changed on write");

   AST_STATUS_OPEN: assert property (
      locked && wrStatus && wrData[wdt_regs_pkg::STS_CLRCNT] && !swResetArm
      |=> clrCnt)
      else $error("status clear refused under lock");

   AST_INHIBIT: assert property (
      restartFlag && configTwo.restartFlagModeBit && !clrFlag
      |=> !systemRestartReq)
      else $error("restart while flag inhibits");

   AST_NV_RELOAD: assert property (
      restartNow && configTwo.nonvolatileReloadOnRestart && !swResetArm
      |=> configOne == $past(nvConfigOne) && nvReadReq)
      else $error("restart reload missing");

   AST_NO_RELOAD: assert property (
      restartNow && !configTwo.nonvolatileReloadOnRestart && !swResetArm
      |=> !nvReadReq)
      else $error("reload without enable");

   AST_POLARITY: assert property (
      !$past(rst) |-> watchdogResetOutput
      == ($past(resetActive) ^ $past(configTwo.resetOutputPolarity)))
      else $error("reset output polarity wrong");

   AST_OPEN_DRAIN: assert property (
      !$past(rst) && configTwo.resetOutputDriveType
      && $stable(configTwo.resetOutputDriveType) && watchdogResetOutputOe
      |-> !watchdogResetOutput)
      else $error("open drain drives high");

   AST_CLEAR_PULSE: assert property (
      wrStatus && wrData[wdt_regs_pkg::STS_CLRFLAG] && !swResetArm
      ##1 !(wrStatus && wrData[wdt_regs_pkg::STS_CLRFLAG])
      |-> clrFlag ##1 (!clrFlag && (!restartFlag || $past(restartNow))))
      else $error("flag clear pulse wrong");

   AST_FLAG_SET: assert property (
      restartNow && !swResetArm |=> restartFlag && systemRestartReq)
      else $error("restart did not set flag");

   AST_CNT_CLEAR: assert property (
      clrCnt && !resetPulse && !swResetArm |=> count == wdt_regs_pkg::RST_CNT)
      else $error("counter not cleared");

   AST_SWRESET: assert property (
      wrSwrst && wrData[wdt_regs_pkg::SWRST_BIT] && !swResetArm
      |=> swResetArm ##1 (!swResetArm && !locked && nvReadReq
      && configOne == $past(nvConfigOne)))
      else $error("software reset sequence wrong");

   AST_THR_OFF: assert property (
      thr == wdt_regs_pkg::THR_OFF |=> !systemRestartReq)
      else $error("restart with counter disabled");

   AST_LOCK_SET: assert property (
      wrCfg2 && wrCfgTwo.configLockBit && !swResetArm && !reloadNow
      |=> locked)
      else $error("lock bit not set by write");

   AST_STATUS_FLAG_OPEN: assert property (
      locked && wrStatus && wrData[wdt_regs_pkg::STS_CLRFLAG] && !swResetArm
      |=> clrFlag)
      else $error("flag clear refused under lock");

   AST_PULLDOWN: assert property (
      wrCfg2 && !swResetArm && !reloadNow
      |=> triggerPulldownEn == $past(wrCfgTwo.triggerInputPulldownSel))
      else $error("pull-down enable does not follow its bit");

   AST_PUSH_PULL: assert property (
      !$past(rst) && !configTwo.resetOutputDriveType
      && $stable(configTwo.resetOutputDriveType) |-> watchdogResetOutputOe)
      else $error("push-pull output not driven");

   AST_DRIVE_DEFAULT: assert property (
      swResetArm |=> configTwo.resetOutputDriveType
      == $past(nvConfigTwo.resetOutputDriveType))
      else $error("drive type default not from image");

   AST_FLAG_HOLD: assert property (
      restartFlag && !clrFlag && !swResetArm |=> restartFlag)
      else $error("restart flag dropped without clear");

   AST_FLAG_QUIET: assert property (
      !restartFlag && !restartNow |=> !restartFlag)
      else $error("restart flag set without restart");

   AST_CNT_PULSE: assert property (
      clrCnt && !(wrStatus && wrData[wdt_regs_pkg::STS_CLRCNT]) |=> !clrCnt)
      else $error("counter clear pulse too long");

   AST_CNT_READ: assert property (
      rdEn && hitStatus |=> rdData[1:0] == $past(count))
      else $error("counter value not in status read");

   AST_SW_SELF_CLEAR: assert property (
      swResetArm |=> !swResetArm)
      else $error("software reset bit stuck");

   AST_CNT_SAT: assert property (
      count == wdt_regs_pkg::CNT_MAX && resetPulse && !restartNow && !clrCnt
      && !swResetArm |=> count == wdt_regs_pkg::CNT_MAX)
      else $error("reset counter wrapped");

   AST_THR_ONE: assert property (
      resetPulse && thr == wdt_regs_pkg::THR_ONE && !inhibit
      |=> systemRestartReq)
      else $error("no restart at threshold one");

   COV_RESTART:   cover property (restartNow ##1 restartFlag);
   COV_LOCK_CLR:  cover property (locked && wrStatus ##1 clrFlag);
   COV_SWRESET:   cover property (swResetArm ##1 nvReadReq);
   COV_INHIBITED: cover property (thrHit && inhibit);
   COV_LOCKED_WR: cover property (locked && wrEn && hitCfg1);

endmodule : watchdog_control_status_regs

/* File: rtl/wdt_regs_pkg.sv */
// register map, field positions and config layouts of the watchdog regs
// assumes an 8-bit register space reached by a plain strobe port
package wdt_regs_pkg;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] OFS_CFG1    = 8'h1c;
   localparam logic [7:0] OFS_CFG2    = 8'h1d;
   localparam logic [7:0] OFS_STATUS  = 8'h1e;
   localparam logic [7:0] OFS_SWRST   = 8'h1f;
   localparam logic [7:0] OFS_INTST   = 8'h22;
   localparam logic [7:0] OFS_INTMASK = 8'h23;

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int STS_CLRFLAG = 4;
   localparam int STS_CLRCNT  = 2;
   localparam int SWRST_BIT   = 0;
   localparam int INT_RESTART = 0;
   localparam int INT_PULSE   = 1;

   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [1:0] RST_CNT   = 2'h0;
   localparam logic [1:0] CNT_MAX   = 2'h3;
   localparam logic [1:0] CNT_STEP  = 2'h1;

   // ************************************************************
   // counter threshold codes and the count at which each fires
   // ************************************************************
   localparam logic [1:0] THR_OFF  = 2'h0;
   localparam logic [1:0] THR_ONE  = 2'h1;
   localparam logic [1:0] THR_TWO  = 2'h2;
   localparam logic [1:0] AT_ONE   = 2'h0;
   localparam logic [1:0] AT_TWO   = 2'h1;
   localparam logic [1:0] AT_FOUR  = 2'h3;

   // ************************************************************
   // config register layouts
   // ************************************************************
   typedef struct packed {
      logic [1:0] closeTime;
      logic [1:0] openTime;
      logic [1:0] longOpenTime;
      logic [1:0] resetCounterThreshold;
   } watchdogConfigOne_t;

   typedef struct packed {
      logic       configLockBit;
      logic [1:0] spare;
      logic       restartFlagModeBit;
      logic       nonvolatileReloadOnRestart;
      logic       triggerInputPulldownSel;
      logic       resetOutputPolarity;
      logic       resetOutputDriveType;
   } watchdogConfigTwo_t;

endpackage : wdt_regs_pkg

/* File: verif/wdt_pulse_source.sv */
// watchdog side model: issues reset pulses on request, resolves the reset pin
// assumes the block's clock and a pull-up on the reset pin
`timescale 1ns/10ps
module wdt_pulse_source (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic fire,
   input  wire logic pinOut,
   input  wire logic pinOe,
   output      logic resetPulse,
   output      logic resetActive,
   output      logic pinLevel
);
   // ************************************************************
   // reset pulse and active window
   // ************************************************************
   logic [2:0] holdCnt;
   wire        startPulse = fire && holdCnt == 3'h0;

   // released open-drain pin rests at the pull-up level
   assign pinLevel    = pinOe ? pinOut : 1'b1;
   assign resetActive = holdCnt != 3'h0;

   always_ff @(posedge clk) begin
      if (rst) begin
         holdCnt    <= 3'h0;
         resetPulse <= 1'b0;
      end else begin
         resetPulse <= startPulse;
         if (startPulse) begin
            holdCnt <= 3'h4;
         end else if (holdCnt != 3'h0) begin
            holdCnt <= holdCnt - 3'h1;
         end
      end
   end
endmodule : wdt_pulse_source

/* File: verif/watchdog_control_status_regs_tb.sv */
// testbench for the watchdog control and status registers
// assumes the pulse source model and the register package
`timescale 1ns/10ps
module watchdog_control_status_regs_tb;
   logic       clk;
   logic       rst;
   logic [7:0] addr;
   logic [7:0] wrData;
   logic       wrEn;
   logic       rdEn;
   logic       fire;
   logic [1:0] pinSnap;
   int         miscompares;
   int         compares;
   int         restarts;
   int         nvReads;
   int         base;
   int         nvBase;
   int         n;
   wire  [7:0] rdData;
   wire        resetPulse;
   wire        resetActive;
   wire        pinOut;
   wire        pinOe;
   wire        pinLevel;
   wire        systemRestartReq;
   wire        nvReadReq;
   wire        triggerPulldownEn;
   wire        irq;
   wdt_regs_pkg::watchdogConfigOne_t nvOne;
   wdt_regs_pkg::watchdogConfigTwo_t nvTwo;
   wdt_regs_pkg::watchdogConfigOne_t cfgOne;
   wdt_regs_pkg::watchdogConfigTwo_t cfgTwo;

   watchdog_control_status_regs #(.ADDR_W(8)) watchdog_control_status_regs_inst (
      .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
      .rdData(rdData), .nvConfigOne(nvOne), .nvConfigTwo(nvTwo),
      .resetPulse(resetPulse), .resetActive(resetActive), .configOne(cfgOne),
      .configTwo(cfgTwo),
      .nvReadReq(nvReadReq), .systemRestartReq(systemRestartReq),
      .watchdogResetOutput(pinOut), .watchdogResetOutputOe(pinOe),
      .triggerPulldownEn(triggerPulldownEn), .irq(irq));

   wdt_pulse_source wdt_pulse_source_inst (
      .clk(clk), .rst(rst), .fire(fire), .pinOut(pinOut), .pinOe(pinOe),
      .resetPulse(resetPulse), .resetActive(resetActive), .pinLevel(pinLevel));

   // ************************************************************
   // bus tasks and checks
   // ************************************************************
   task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr   <= a;
      wrData <= d;
      wrEn   <= 1'b1;
      @(posedge clk);
      wrEn   <= 1'b0;
      // let the written register settle before the caller looks at outputs
      #1;
   endtask : wr

   task rdChk(input logic [7:0] a, input logic [7:0] exp, input string msg);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      #1 chk(rdData, exp, msg);
   endtask : rdChk

   task firePulse;
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      @(posedge clk);
      #1 pinSnap = {pinOe, pinLevel};
      repeat (8) @(posedge clk);
   endtask : firePulse

   task wrap_up;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   always @(posedge clk) begin
      if (systemRestartReq === 1'b1) restarts++;
      if (nvReadReq === 1'b1) nvReads++;
   end

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      #20000;
      miscompares++;
      $display("mismatch at %0t: timeout", $time);
      wrap_up();
   end

   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      {addr, wrData, wrEn, rdEn, fire} = '0;
      {miscompares, compares, restarts, nvReads} = '0;
      nvOne = 8'h02;
      nvTwo = 8'h89;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdChk(wdt_regs_pkg::OFS_CFG2, 8'h09, "config two default");
      rdChk(wdt_regs_pkg::OFS_CFG1, 8'h02, "config one default");
      rdChk(wdt_regs_pkg::OFS_STATUS, 8'h00, "status default");
      rdChk(8'h30, 8'h00, "unmapped read");
      $display("test defaults done");
      wr(wdt_regs_pkg::OFS_CFG1, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(wdt_regs_pkg::OFS_CFG2, {5'h0, i[1], i[1:0]});
         chk({7'h0, triggerPulldownEn}, {7'h0, i[1]}, "pull-down enable");
         firePulse();
         n = (i[0] && !i[1]) ? 0 : 1;
         chk({6'h0, pinSnap}, {6'h0, n[0], ~i[1]}, "reset pin active");
      end
      rdChk(wdt_regs_pkg::OFS_STATUS, 8'h03, "count saturates, no restart");
      chk(8'(restarts), 8'h00, "threshold off restarts");
      $display("test pin config done");
      wr(wdt_regs_pkg::OFS_STATUS, 8'h04);
      nvBase = nvReads;
      for (int c = 1; c < 4; c++) begin
         n = (c == 3) ? 4 : c;
         wr(wdt_regs_pkg::OFS_CFG1, c[7:0]);
         base = restarts;
         for (int k = 1; k < n; k++) firePulse();
         rdChk(wdt_regs_pkg::OFS_STATUS, 8'(n - 1), "count before threshold");
         firePulse();
         chk(8'(restarts - base), 8'h01, "restart at threshold");
         rdChk(wdt_regs_pkg::OFS_STATUS, 8'h08, "flag set, count zero");
         wr(wdt_regs_pkg::OFS_STATUS, 8'h10);
         rdChk(wdt_regs_pkg::OFS_STATUS, 8'h00, "flag cleared");
      end
      chk(8'(nvReads - nvBase), 8'h00, "no reload when off");
      $display("test thresholds done");
      wr(wdt_regs_pkg::OFS_CFG1, 8'h01);
      wr(wdt_regs_pkg::OFS_CFG2, 8'h10);
      base = restarts;
      firePulse();
      firePulse();
      chk(8'(restarts - base), 8'h01, "set flag inhibits restart");
      rdChk(wdt_regs_pkg::OFS_STATUS, 8'h09, "flag held, pulse counted");
      wr(wdt_regs_pkg::OFS_STATUS, 8'h14);
      rdChk(wdt_regs_pkg::OFS_STATUS, 8'h00, "both cleared");
      $display("test flag mode done");
      rdChk(wdt_regs_pkg::OFS_INTST, 8'h03, "event status");
      chk({7'h0, irq}, 8'h01, "irq raised");
      wr(wdt_regs_pkg::OFS_INTMASK, 8'h03);
      chk({7'h0, irq}, 8'h00, "irq masked");
      wr(wdt_regs_pkg::OFS_INTMASK, 8'h00);
      wr(wdt_regs_pkg::OFS_INTST, 8'h03);
      chk({7'h0, irq}, 8'h00, "irq cleared");
      rdChk(wdt_regs_pkg::OFS_INTST, 8'h00, "event status cleared");
      $display("test interrupt done");
      wr(wdt_regs_pkg::OFS_CFG2, 8'h08);
      nvBase = nvReads;
      firePulse();
      chk(8'(nvReads - nvBase), 8'h01, "reload on restart");
      rdChk(wdt_regs_pkg::OFS_CFG1, 8'h02, "config one reloaded");
      rdChk(wdt_regs_pkg::OFS_CFG2, 8'h09, "config two reloaded");
      chk(cfgOne, 8'h02, "config one output reloaded");
      $display("test reload done");
      wr(wdt_regs_pkg::OFS_CFG2, 8'h80);
      wr(wdt_regs_pkg::OFS_CFG2, 8'h00);
      rdChk(wdt_regs_pkg::OFS_CFG2, 8'h80, "lock sticky");
      wr(wdt_regs_pkg::OFS_CFG1, 8'hff);
      rdChk(wdt_regs_pkg::OFS_CFG1, 8'h02, "locked config one kept");
      chk(cfgTwo, 8'h80, "config two output locked");
      firePulse();
      rdChk(wdt_regs_pkg::OFS_STATUS, 8'h09, "status while locked");
      wr(wdt_regs_pkg::OFS_STATUS, 8'hf4);
      rdChk(wdt_regs_pkg::OFS_STATUS, 8'he0, "cleared while locked, spare kept");
      $display("test lock done");
      nvBase = nvReads;
      wr(wdt_regs_pkg::OFS_SWRST, 8'h01);
      repeat (2) @(posedge clk);
      #1 chk(8'(nvReads - nvBase), 8'h01, "soft reset reload");
      rdChk(wdt_regs_pkg::OFS_CFG2, 8'h09, "soft reset defaults");
      rdChk(wdt_regs_pkg::OFS_SWRST, 8'h00, "soft reset self clears");
      rdChk(wdt_regs_pkg::OFS_STATUS, 8'h00, "soft reset clears status");
      $display("test soft reset done");
      wrap_up();
   end
endmodule : watchdog_control_status_regs_tb
